// [hw/pb_vol_regs.svh]
`ifndef PB_VOL_REGS_SVH
`define PB_VOL_REGS_SVH
// Register indices, byte address is four times the index
`define IDX_SETTINGS  8'h3F
`define IDX_ASSIGN    8'h40
`define IDX_DEBOUNCE  8'h41
`define IDX_PINMAP    8'h60
`define IDX_STATUS    8'h61
`define IDX_ADC_GAIN0 8'h62
`define IDX_DAC_GAIN0 8'h66
// Reset values
`define RST_SETTINGS  8'h00
`define RST_ASSIGN    8'h87
`define RST_DEBOUNCE  8'h05
`define RST_PINMAP    8'h08
`define RST_GAIN      8'h00
// Field positions
`define ASSIGN_SEL_LSB  0
`define ASSIGN_RATE_LSB 3
`define ASSIGN_STEP_LSB 6
`define SET_HOLD_LSB    0
`define SET_INIT_LSB    3
`define PINMAP_DOWN_LSB 3
`define SEL_NONE        3'h7
`define SEL_RESERVED    3'h6
`define DEB_BYPASS      3'h7
`define MP_PINS         5
// Timing base: one tick per microsecond
`define CLK_PERIOD_NS   50
`define TICK_TIME_NS    1000
`define TICK_CYCLES     ((`TICK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEB_US_0        300
`define DEB_US_1        600
`define DEB_US_2        900
`define DEB_US_3        5000
`define DEB_US_4        10000
`define DEB_US_5        20000
`define DEB_US_6        40000
`define HOLD_MS_0       150
`define HOLD_MS_1       300
`define HOLD_MS_2       450
`define HOLD_MS_3       600
`define HOLD_MS_4       900
`define HOLD_MS_5       1200
`define US_PER_MS       1000
`define US_PER_S        1000000
`define MDB_PER_DB      1000
`define UNIT_MDB        375
`define RAMP_DBPS_0     60
`define RAMP_DBPS_1     48
`define RAMP_DBPS_2     36
`define RAMP_DBPS_3     30
`define RAMP_DBPS_4     24
`define RAMP_DBPS_5     18
`define RAMP_DBPS_6     12
`define RAMP_DBPS_7     6
// Volume in 0.375 dB attenuation units
`define STEP_UNITS_0    8'd1
`define STEP_UNITS_1    8'd4
`define STEP_UNITS_2    8'd8
`define STEP_UNITS_3    8'd12
`define INIT_UNITS      8'd4
`define VOL_FLOOR       8'hFF
`endif

// [hw/pb_vol_pkg.sv]
`default_nettype none
package pb_vol_pkg;
  typedef enum logic [1:0] {BTN_IDLE, BTN_HOLD, BTN_RAMP} btnState_t;

  typedef struct packed {
    logic [4:0][2:0]  sync;
    logic [4:0][15:0] cnt;
    logic [4:0]       level;
  } debState_t;

  typedef struct packed {
    logic [7:0]       settings;
    logic [7:0]       assign_;
    logic [7:0]       debounce;
    logic [7:0]       pinMap;
    logic [3:0][7:0]  adcReg;
    logic [1:0][7:0]  dacReg;
    logic [4:0]       preCnt;
    logic             tick;
    logic [7:0]       vol;
    logic             enPrev;
    logic             settingsWritten;
    btnState_t        btn;
    logic             dirUp;
    logic [20:0]      holdCnt;
    logic [16:0]      rampCnt;
    logic             ack;
    logic [31:0]      rdData;
    logic [3:0][7:0]  adcOut;
    logic [1:0][7:0]  dacOut;
  } topState_t;
endpackage
`default_nettype wire

// [hw/mp_debounce.sv]
`include "pb_vol_regs.svh"
`default_nettype none
module mp_debounce (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Control
  input  wire logic                tick,
  input  wire logic [2:0]          mode,
  // Pins
  input  wire logic [`MP_PINS-1:0] pinRaw,
  output logic      [`MP_PINS-1:0] pinLevel
);
  pb_vol_pkg::debState_t q;
  pb_vol_pkg::debState_t d;
  logic [15:0]           limUs;

  function automatic logic [15:0] debLimit(input logic [2:0] code);
    case (code)
      3'h0: debLimit = 16'(`DEB_US_0);
      3'h1: debLimit = 16'(`DEB_US_1);
      3'h2: debLimit = 16'(`DEB_US_2);
      3'h3: debLimit = 16'(`DEB_US_3);
      3'h4: debLimit = 16'(`DEB_US_4);
      3'h5: debLimit = 16'(`DEB_US_5);
      default: debLimit = 16'(`DEB_US_6);
    endcase
  endfunction

  assign limUs = debLimit(mode);

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    for (int i = 0; i < `MP_PINS; i++)
    begin
      d.sync[i] = {q.sync[i][1:0], pinRaw[i]};
      if (q.sync[i][1] != q.sync[i][2] || q.sync[i][2] == q.level[i])
        d.cnt[i] = 16'h0000;
      else if (mode == `DEB_BYPASS)
        d.level[i] = q.sync[i][2];
      else if (tick)
      begin
        if (q.cnt[i] >= limUs - 16'h0001)
        begin
          d.level[i] = q.sync[i][2];
          d.cnt[i] = 16'h0000;
        end
        else
          d.cnt[i] = q.cnt[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign pinLevel = q.level;

  ////////////////////////////////////////////////////////////////////////
  property p_deb_settle;
    @(posedge core_clk) disable iff (rst)
      ($past(mode) != `DEB_BYPASS && $changed(q.level[0]))
        |-> ($past(q.cnt[0]) == $past(limUs) - 16'h0001 && $past(tick));
  endproperty
  a_deb_settle: assert property (p_deb_settle) else $error("debounce accepted early");
endmodule // mp_debounce
`default_nettype wire

// [hw/pushbutton_volume_debounce.sv]
// Summary of operation
// - Selector picks group: ADC0/1, ADC2/3, all ADCs, both DACs, DAC0, DAC1, reserved.
// - Button volume is active only while the selector differs from 111.
// - Selector 111 leaves each converter on its own channel gain register.
// - Pin debounce time selectable 300 us to 40 ms; code 111 bypasses.
// - Debounce time field resets to 5, meaning 20 ms.
// - Held button ramps volume at 60 down to 6 dB per second by code.
// - Each press steps volume by 0.375, 1.5, 3.0 or 4.5 dB; reset 3.0.
// - Held button waits 150 to 1200 ms before ramping starts.
`include "pb_vol_regs.svh"
`default_nettype none
module pushbutton_volume_debounce #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [9:0]          adr_i,
  input  wire logic [31:0]         dat_i,
  input  wire logic [3:0]          sel_i,
  output logic                     ack_o,
  output logic      [31:0]         dat_o,
  // Multipurpose pins
  input  wire logic [`MP_PINS-1:0] multipurposePin,
  // Converter gains
  output logic      [3:0][7:0]     adcChannelGain,
  output logic      [1:0][7:0]     dacChannelGain
);
  pb_vol_pkg::topState_t q;
  pb_vol_pkg::topState_t d;
  logic [`MP_PINS-1:0]   pinLevel;
  logic [2:0]            selQ;
  logic                  en;
  logic                  justEn;
  logic                  upBtn;
  logic                  downBtn;
  logic                  held;
  logic [7:0]            stepUnits;
  logic [20:0]           holdLimit;
  logic [16:0]           rampLimit;
  logic [7:0]            idx;

  mp_debounce u_debounce (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (q.tick),
    .mode     (q.debounce[2:0]),
    .pinRaw   (multipurposePin),
    .pinLevel (pinLevel)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic inGroup(input logic [2:0] s, input logic dac, input int ch);
    case (s)
      3'h0: inGroup = !dac && ch < 2;
      3'h1: inGroup = !dac && ch >= 2;
      3'h2: inGroup = !dac;
      3'h3: inGroup = dac;
      3'h4: inGroup = dac && ch == 0;
      3'h5: inGroup = dac && ch == 1;
      default: inGroup = 1'b0; // Reserved code drives nothing
    endcase
  endfunction

  function automatic logic [7:0] stepVol(input logic [7:0] v, input logic up,
                                         input logic [7:0] amt);
    if (up)
      stepVol = (v > amt) ? v - amt : 8'h00;
    else
      stepVol = (9'(v) + 9'(amt) > 9'h0FF) ? `VOL_FLOOR : v + amt;
  endfunction

  function automatic logic [16:0] rampUs(input int dbps);
    rampUs = 17'(`US_PER_S / `MDB_PER_DB * `UNIT_MDB / dbps);
  endfunction

  function automatic logic pinSel(input logic [`MP_PINS-1:0] lv, input logic [2:0] p);
    pinSel = (int'(p) < `MP_PINS) ? lv[p] : 1'b0;
  endfunction

  assign selQ = q.assign_[`ASSIGN_SEL_LSB +: 3];
  assign en = selQ != `SEL_NONE;
  assign justEn = en && !q.enPrev;
  // Pins are high while pressed; pin mapping lives in its own register
  assign upBtn = pinSel(pinLevel, q.pinMap[2:0]);
  assign downBtn = pinSel(pinLevel, q.pinMap[`PINMAP_DOWN_LSB +: 3]);
  assign held = q.dirUp ? upBtn : downBtn;
  assign idx = adr_i[9:2];

  always_comb
  begin
    case (q.assign_[`ASSIGN_STEP_LSB +: 2])
      2'h0: stepUnits = `STEP_UNITS_0;
      2'h1: stepUnits = `STEP_UNITS_1;
      2'h2: stepUnits = `STEP_UNITS_2;
      default: stepUnits = `STEP_UNITS_3;
    endcase
    case (q.settings[`SET_HOLD_LSB +: 3])
      3'h0: holdLimit = 21'(`HOLD_MS_0 * `US_PER_MS);
      3'h1: holdLimit = 21'(`HOLD_MS_1 * `US_PER_MS);
      3'h2: holdLimit = 21'(`HOLD_MS_2 * `US_PER_MS);
      3'h3: holdLimit = 21'(`HOLD_MS_3 * `US_PER_MS);
      3'h4: holdLimit = 21'(`HOLD_MS_4 * `US_PER_MS);
      default: holdLimit = 21'(`HOLD_MS_5 * `US_PER_MS); // Undefined codes hold longest
    endcase
    case (q.assign_[`ASSIGN_RATE_LSB +: 3])
      3'h0: rampLimit = rampUs(`RAMP_DBPS_0);
      3'h1: rampLimit = rampUs(`RAMP_DBPS_1);
      3'h2: rampLimit = rampUs(`RAMP_DBPS_2);
      3'h3: rampLimit = rampUs(`RAMP_DBPS_3);
      3'h4: rampLimit = rampUs(`RAMP_DBPS_4);
      3'h5: rampLimit = rampUs(`RAMP_DBPS_5);
      3'h6: rampLimit = rampUs(`RAMP_DBPS_6);
      default: rampLimit = rampUs(`RAMP_DBPS_7);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    d.ack = 1'b0;
    // Microsecond tick keeps every long count small
    if (q.preCnt >= 5'(TICK_CYCLES - 1))
    begin
      d.preCnt = 5'h00;
      d.tick = 1'b1;
    end
    else
      d.preCnt = q.preCnt + 5'h01;

    // Bus: answer one cycle after the request, unmapped reads zero
    if (cyc_i && stb_i && !q.ack)
    begin
      d.ack = 1'b1;
      d.rdData = 32'h0000_0000;
      if (idx == `IDX_SETTINGS)
        d.rdData[7:0] = q.settings;
      else if (idx == `IDX_ASSIGN)
        d.rdData[7:0] = q.assign_;
      else if (idx == `IDX_DEBOUNCE)
        d.rdData[7:0] = q.debounce;
      else if (idx == `IDX_PINMAP)
        d.rdData[7:0] = q.pinMap;
      else if (idx == `IDX_STATUS)
        d.rdData[15:0] = {en, pinLevel, q.btn, q.vol};
      else if (idx >= `IDX_ADC_GAIN0 && idx < `IDX_DAC_GAIN0)
        d.rdData[7:0] = q.adcReg[2'(idx - `IDX_ADC_GAIN0)];
      else if (idx >= `IDX_DAC_GAIN0 && idx < `IDX_DAC_GAIN0 + 8'h02)
        d.rdData[7:0] = q.dacReg[1'(idx - `IDX_DAC_GAIN0)];
      if (we_i && sel_i[0])
      begin
        if (idx == `IDX_SETTINGS)
        begin
          d.settings = dat_i[7:0];
          d.settingsWritten = 1'b1;
        end
        else if (idx == `IDX_ASSIGN)
          d.assign_ = dat_i[7:0];
        else if (idx == `IDX_DEBOUNCE)
          d.debounce = dat_i[7:0];
        else if (idx == `IDX_PINMAP)
          d.pinMap = dat_i[7:0];
        else if (idx >= `IDX_ADC_GAIN0 && idx < `IDX_DAC_GAIN0)
          d.adcReg[2'(idx - `IDX_ADC_GAIN0)] = dat_i[7:0];
        else if (idx >= `IDX_DAC_GAIN0 && idx < `IDX_DAC_GAIN0 + 8'h02)
          d.dacReg[1'(idx - `IDX_DAC_GAIN0)] = dat_i[7:0];
      end
    end

    // Button volume engine
    d.enPrev = en;
    if (!en)
      d.btn = pb_vol_pkg::BTN_IDLE;
    else if (justEn)
    begin
      // Without prior settings the level opens fully attenuated
      d.vol = q.settingsWritten ? q.settings[`SET_INIT_LSB +: 5] * `INIT_UNITS
                                : `VOL_FLOOR;
      d.btn = pb_vol_pkg::BTN_IDLE;
    end
    else
    begin
      case (q.btn)
        pb_vol_pkg::BTN_IDLE:
          if (upBtn || downBtn)
          begin
            d.dirUp = upBtn; // Up wins when both are pressed
            d.vol = stepVol(q.vol, upBtn, stepUnits);
            d.holdCnt = 21'h0;
            d.btn = pb_vol_pkg::BTN_HOLD;
          end
        pb_vol_pkg::BTN_HOLD:
          if (!held)
            d.btn = pb_vol_pkg::BTN_IDLE;
          else if (q.tick)
          begin
            if (q.holdCnt >= holdLimit - 21'h1)
            begin
              d.btn = pb_vol_pkg::BTN_RAMP;
              d.rampCnt = 17'h0;
            end
            else
              d.holdCnt = q.holdCnt + 21'h1;
          end
        default:
          if (!held)
            d.btn = pb_vol_pkg::BTN_IDLE;
          else if (q.tick)
          begin
            if (q.rampCnt >= rampLimit - 17'h1)
            begin
              d.vol = stepVol(q.vol, q.dirUp, 8'h01);
              d.rampCnt = 17'h0;
            end
            else
              d.rampCnt = q.rampCnt + 17'h1;
          end
      endcase
    end

    for (int i = 0; i < 4; i++)
      d.adcOut[i] = (en && inGroup(selQ, 1'b0, i)) ? q.vol : q.adcReg[i];
    for (int i = 0; i < 2; i++)
      d.dacOut[i] = (en && inGroup(selQ, 1'b1, i)) ? q.vol : q.dacReg[i];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.settings <= `RST_SETTINGS;
      q.assign_ <= `RST_ASSIGN;
      q.debounce <= `RST_DEBOUNCE;
      q.pinMap <= `RST_PINMAP;
      q.vol <= `VOL_FLOOR;
    end
    else
      q <= d;
  end

  assign ack_o = q.ack;
  assign dat_o = q.rdData;
  assign adcChannelGain = q.adcOut;
  assign dacChannelGain = q.dacOut;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_press;
    q.btn == pb_vol_pkg::BTN_IDLE && en && !justEn && (upBtn || downBtn);
  endsequence
  sequence s_ramp_step;
    q.btn == pb_vol_pkg::BTN_RAMP ##1 (q.btn == pb_vol_pkg::BTN_RAMP && $changed(q.vol));
  endsequence

  property p_adc_group;
    (en && selQ == 3'h0) |=> (adcChannelGain[0] == $past(q.vol)
                              && adcChannelGain[2] == $past(q.adcReg[2]));
  endproperty
  a_adc_group: assert property (p_adc_group) else $error("adc group wrong");
  property p_dac_group;
    (selQ == 3'h4) |=> (dacChannelGain[0] == $past(q.vol)
                        && dacChannelGain[1] == $past(q.dacReg[1]));
  endproperty
  a_dac_group: assert property (p_dac_group) else $error("dac group wrong");
  property p_disabled_idle;
    !en |=> q.btn == pb_vol_pkg::BTN_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("engine ran disabled");
  property p_own_gain;
    !en |=> (adcChannelGain == $past(q.adcReg) && dacChannelGain == $past(q.dacReg));
  endproperty
  a_own_gain: assert property (p_own_gain) else $error("own gain not used");
  property p_deb_reset;
    $past(rst) |-> q.debounce == `RST_DEBOUNCE;
  endproperty
  a_deb_reset: assert property (p_deb_reset) else $error("debounce reset wrong");
  property p_press_step;
    (s_press and upBtn) |=> q.vol == stepVol($past(q.vol), 1'b1, $past(stepUnits));
  endproperty
  a_press_step: assert property (p_press_step) else $error("press step wrong");
  property p_hold_time;
    $rose(q.btn == pb_vol_pkg::BTN_RAMP) |-> $past(q.holdCnt) == $past(holdLimit) - 21'h1;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("ramp began early");
  property p_ramp_rate;
    s_ramp_step |-> ($past(q.rampCnt) == $past(rampLimit) - 17'h1 && $past(q.tick));
  endproperty
  a_ramp_rate: assert property (p_ramp_rate) else $error("ramp rate wrong");
endmodule // pushbutton_volume_debounce
`default_nettype wire

// [tb/button_model.sv]
`default_nettype none
module button_model (
  // Clock
  input  wire logic       core_clk,
  // Stimulus from the bench
  input  wire logic [4:0] pressed,
  input  wire logic [7:0] bounceLen,
  // Contacts
  output var  logic [4:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] prevQ;
  logic [4:0] maskQ;
  int         left;

  initial
  begin
    pin = 5'h00;
    prevQ = 5'h00;
    maskQ = 5'h00;
    left = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Contacts chatter for bounceLen cycles after each change, then settle
  always @(posedge core_clk)
  begin
    if (pressed !== prevQ)
    begin
      prevQ <= pressed;
      maskQ <= pressed ^ prevQ;
      left <= bounceLen;
      pin <= pressed;
    end
    else if (left > 0)
    begin
      left <= left - 1;
      pin <= (left == 1) ? pressed : pin ^ maskQ;
    end
    else
      pin <= pressed;
  end
endmodule // button_model
`default_nettype wire

// [tb/testbench.sv]
`include "pb_vol_regs.svh"
`default_nettype none
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Longest path is the debounce scenario, well under this
  localparam int CEIL = 40000;

  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [9:0]       adr = 10'h000;
  logic [31:0]      wdat = 32'h0;
  logic [3:0]       sel = 4'h0;
  logic             ack;
  logic [31:0]      rdat;
  logic [4:0]       pinPress = 5'h00;
  logic [7:0]       bounceLen = 8'h00;
  logic [4:0]       pin;
  logic [3:0][7:0]  adcGain;
  logic [1:0][7:0]  dacGain;
  logic [7:0]       own [6] = '{default: 8'h00};
  int               failures = 0;
  int               cmpCount = 0;
  int               cycles = 0;

  always #25 core_clk = ~core_clk;

  // Tick every cycle: all times shrink twentyfold
  pushbutton_volume_debounce #(.TICK_CYCLES(1)) uut (
    .core_clk(core_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .ack_o(ack), .dat_o(rdat), .multipurposePin(pin),
    .adcChannelGain(adcGain), .dacChannelGain(dacGain));

  button_model buttons (.core_clk(core_clk), .pressed(pinPress), .bounceLen(bounceLen),
                        .pin(pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      failures++;
      end_sim();
    end
  end

  // Called right after an edge; ack is read before that edge's updates land
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    sel <= s;
    @(posedge core_clk);
    // Only the bench timeout ends a wait
    while (ack !== 1'b1)
      @(posedge core_clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, 4'hF, r);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] r);
    wb(1'b0, idx, 8'h00, 4'hF, r);
  endtask

  task automatic push(input logic [4:0] lv, input logic [7:0] bl, input int w);
    bounceLen <= bl;
    pinPress <= lv;
    repeat (w) @(posedge core_clk);
  endtask

  function automatic logic [5:0] grp(input logic [2:0] s);
    case (s)
      3'h0: return 6'b000011;
      3'h1: return 6'b001100;
      3'h2: return 6'b001111;
      3'h3: return 6'b110000;
      3'h4: return 6'b010000;
      3'h5: return 6'b100000;
      default: return 6'b000000;
    endcase
  endfunction

  task automatic chk_gains(input logic [5:0] g, input logic [7:0] vol);
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 6; i++)
      `CHK("gain", g[i] ? vol : own[i], i < 4 ? adcGain[i] : dacGain[i - 4])
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_start_level;
    wr(`IDX_ASSIGN, 8'h9B);
    chk_gains(6'b110000, 8'hFF);
    $display("test start_level done");
  endtask

  task automatic t_regs;
    logic [31:0] r;
    rd(`IDX_SETTINGS, r);
    `CHK("settings", 32'h00, r)
    rd(`IDX_ASSIGN, r);
    `CHK("assign", 32'h87, r)
    rd(`IDX_DEBOUNCE, r);
    `CHK("debounce", 32'h05, r)
    wb(1'b1, `IDX_DEBOUNCE, 8'h03, 4'hE, r);
    rd(`IDX_DEBOUNCE, r);
    `CHK("debounce masked", 32'h05, r)
    wr(8'h50, 8'hAA);
    rd(8'h50, r);
    `CHK("unmapped", 32'h00, r)
    $display("test regs done");
  endtask

  task automatic t_own;
    for (int i = 0; i < 6; i++)
    begin
      own[i] = 8'(8'h11 * (i + 1));
      wr(8'(`IDX_ADC_GAIN0 + i), own[i]);
    end
    chk_gains(6'b000000, 8'h00);
    $display("test own_gain done");
  endtask

  task automatic t_groups;
    // Start level 2 is 3 dB, eight units
    wr(`IDX_SETTINGS, 8'h10);
    for (int s = 0; s < 7; s++)
    begin
      wr(`IDX_ASSIGN, {5'b10000, 3'(s)});
      chk_gains(grp(3'(s)), 8'h08);
    end
    wr(`IDX_ASSIGN, 8'h87);
    chk_gains(6'b000000, 8'h00);
    $display("test groups done");
  endtask

  task automatic t_debounce;
    logic [31:0] r;
    int t[4] = '{300, 600, 900, 5000};
    for (int c = 0; c < 4; c++)
    begin
      wr(`IDX_DEBOUNCE, 8'(c));
      push(5'h01, 8'h00, t[c] - 10);
      rd(`IDX_STATUS, r);
      `CHK("early", 1'b0, r[10])
      repeat (20) @(posedge core_clk);
      rd(`IDX_STATUS, r);
      `CHK("settled", 1'b1, r[10])
      push(5'h00, 8'h00, t[c] + 20);
    end
    // Chatter must restart the timing
    wr(`IDX_DEBOUNCE, 8'h00);
    push(5'h01, 8'd200, 440);
    rd(`IDX_STATUS, r);
    `CHK("bounce early", 1'b0, r[10])
    repeat (100) @(posedge core_clk);
    rd(`IDX_STATUS, r);
    `CHK("bounce settled", 1'b1, r[10])
    push(5'h00, 8'd200, 560);
    wr(`IDX_DEBOUNCE, 8'h07);
    push(5'h01, 8'h00, 6);
    rd(`IDX_STATUS, r);
    `CHK("bypass", 1'b1, r[10])
    push(5'h00, 8'h00, 10);
    $display("test debounce done");
  endtask

  task automatic t_steps;
    logic [31:0] r;
    int u[4] = '{1, 4, 8, 12};
    wr(`IDX_DEBOUNCE, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      // Leaving 111 again reloads the start level
      wr(`IDX_ASSIGN, {2'(s), 6'b000111});
      wr(`IDX_ASSIGN, {2'(s), 6'b000000});
      push(5'h02, 8'h00, 320);
      rd(`IDX_STATUS, r);
      `CHK("held state", 2'h1, r[9:8])
      `CHK("enabled", 1'b1, r[15])
      `CHK("volume", 8'(8 + u[s]), r[7:0])
      chk_gains(6'b000011, 8'(8 + u[s]));
      push(5'h00, 8'h00, 320);
      push(5'h01, 8'h00, 320);
      chk_gains(6'b000011, 8'h08);
      push(5'h00, 8'h00, 320);
    end
    $display("test steps done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_start_level();
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_own();
    t_groups();
    t_debounce();
    t_steps();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
